// >>> shared/stb_defs.svh
`ifndef STB_DEFS_SVH
`define STB_DEFS_SVH

// Clock rate and tick periods
`define STB_CLK_HZ 125000000
`define STB_TB1_MS 1
`define STB_TB10_MS 10
`define STB_TB100_MS 100
`define STB_CYC_PER_MS ((`STB_CLK_HZ) / 1000)

// Timer number ranges
`define STB_T1MS_A 8'd32
`define STB_T1MS_B 8'd96
`define STB_T10_LO_A 8'd33
`define STB_T10_HI_A 8'd36
`define STB_T10_LO_B 8'd97
`define STB_T10_HI_B 8'd100

// Reset values
`define STB_ET_RST 16'h0000
`define STB_MS_RST 32'h0000_0000

`endif

// >>> shared/stb_pkg.sv
package stb_pkg;
  typedef enum logic [1:0] {
    STB_ON_DELAY,
    STB_OFF_DELAY,
    STB_PULSE
  } stb_mode_t;
  typedef enum logic [1:0] {
    STB_TB_1MS,
    STB_TB_10MS,
    STB_TB_100MS
  } stb_base_t;
endpackage

// >>> logic/stb_tick_gen.sv
`timescale 1ns/100ps
`include "stb_defs.svh"
module stb_tick_gen #(
  parameter int CYC_PER_MS = `STB_CYC_PER_MS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Ticks, one cycle each
  output logic o_tick_1ms,
  output logic o_tick_10ms,
  output logic o_tick_100ms
);
  logic [31:0] cyc;
  logic [3:0] div10;
  logic [3:0] div100;
  logic ms;

  assign ms = (cyc == 32'(CYC_PER_MS - 1));

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cyc <= 32'h0;
    end else if (ms) begin
      cyc <= 32'h0;
    end else begin
      cyc <= cyc + 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      div10 <= 4'h0;
      div100 <= 4'h0;
      o_tick_1ms <= 1'b0;
      o_tick_10ms <= 1'b0;
      o_tick_100ms <= 1'b0;
    end else begin
      o_tick_1ms <= ms;
      o_tick_10ms <= ms && div10 == 4'h9;
      o_tick_100ms <= ms && div10 == 4'h9 && div100 == 4'h9;
      if (ms) begin
        div10 <= (div10 == 4'h9) ? 4'h0 : div10 + 4'h1;
        if (div10 == 4'h9) begin
          div100 <= (div100 == 4'h9) ? 4'h0 : div100 + 4'h1;
        end
      end
    end
  end
endmodule

// >>> logic/stb_timer_cell.sv
`timescale 1ns/100ps
`include "stb_defs.svh"
module stb_timer_cell
  import stb_pkg::*;
#(
  parameter int ET_W = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Control
  input stb_mode_t i_mode,
  input wire logic i_tick,
  input wire logic i_enable,
  input wire logic [ET_W-1:0] i_preset_time,
  // Results
  output logic o_q,
  output logic [ET_W-1:0] o_elapsed_count
);
  logic en_d;
  logic running;
  logic rise;
  logic fall;
  logic at_pt;

  assign rise = i_enable && !en_d;
  assign fall = !i_enable && en_d;
  assign at_pt = (o_elapsed_count >= i_preset_time);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      en_d <= 1'b0;
    end else begin
      en_d <= i_enable;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_q <= 1'b0;
      running <= 1'b0;
      o_elapsed_count <= `STB_ET_RST;
    end else begin
      unique case (i_mode)
        STB_ON_DELAY: begin
          running <= 1'b0;
          if (!i_enable) begin
            o_q <= 1'b0;
            o_elapsed_count <= `STB_ET_RST;
          end else if (at_pt) begin
            o_q <= 1'b1;
          end else if (i_tick) begin
            o_elapsed_count <= o_elapsed_count + 1'b1;
          end
        end
        STB_OFF_DELAY: begin
          if (i_enable) begin
            o_q <= 1'b1;
            running <= 1'b0;
            o_elapsed_count <= `STB_ET_RST;
          end else if (fall) begin
            running <= 1'b1;
          end else if (running) begin
            if (at_pt) begin
              o_q <= 1'b0;
              running <= 1'b0;
            end else if (i_tick) begin
              o_elapsed_count <= o_elapsed_count + 1'b1;
            end
          end
        end
        STB_PULSE: begin
          if (rise && !running && !o_q) begin
            o_q <= 1'b1;
            running <= 1'b1;
            o_elapsed_count <= `STB_ET_RST;
          end else if (running) begin
            if (at_pt) begin
              o_q <= 1'b0;
              running <= 1'b0;
            end else if (i_tick) begin
              o_elapsed_count <= o_elapsed_count + 1'b1;
            end
          end else if (!i_enable) begin
            o_elapsed_count <= `STB_ET_RST;
          end
        end
        default: begin
          o_q <= 1'b0;
          running <= 1'b0;
        end
      endcase
    end
  end
endmodule

// >>> logic/stb_timer_bank.sv
`timescale 1ns/100ps
`include "stb_defs.svh"
module stb_timer_bank
  import stb_pkg::*;
#(
  parameter int N_TMR = 4,
  parameter int ET_W = 16,
  parameter int CYC_PER_MS = `STB_CYC_PER_MS,
  parameter logic [N_TMR*8-1:0] TMR_NUM = {8'd37, 8'd33, 8'd96, 8'd32}
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Timer controls, one slot per instance
  input wire logic [N_TMR*2-1:0] I_MODE,
  input wire logic [N_TMR-1:0] I_ENABLE,
  input wire logic [N_TMR*ET_W-1:0] I_PRESET_TIME,
  // Timer results
  output logic [N_TMR-1:0] O_Q,
  output logic [N_TMR*ET_W-1:0] O_ELAPSED_COUNT,
  // Interval requests
  input wire logic I_BEGIN_INTERVAL_SNAPSHOT,
  input wire logic I_CALCULATE_INTERVAL_DIFFERENCE,
  input wire logic [31:0] I_INTERVAL_START,
  // Interval answer
  output logic O_INTERVAL_VALID,
  output logic [31:0] O_INTERVAL_VALUE,
  output logic [31:0] O_MS_COUNT
);
  // ==========================================================
  // Time base decode
  function automatic stb_base_t base_of(input logic [7:0] n);
    if (n == `STB_T1MS_A || n == `STB_T1MS_B) begin
      return STB_TB_1MS;
    end else if ((n >= `STB_T10_LO_A && n <= `STB_T10_HI_A) ||
                 (n >= `STB_T10_LO_B && n <= `STB_T10_HI_B)) begin
      return STB_TB_10MS;
    end else begin
      return STB_TB_100MS;
    end
  endfunction

  // ==========================================================
  // Tick generation
  logic tick_1ms;
  logic tick_10ms;
  logic tick_100ms;

  stb_tick_gen #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .o_tick_1ms(tick_1ms),
    .o_tick_10ms(tick_10ms),
    .o_tick_100ms(tick_100ms)
  );

  // ==========================================================
  // Timer instances
  logic [N_TMR-1:0] q;
  logic [N_TMR*ET_W-1:0] et;

  for (genvar g = 0; g < N_TMR; g++) begin : g_tmr
    localparam stb_base_t BASE = base_of(TMR_NUM[g*8 +: 8]);
    logic tick;
    assign tick = (BASE == STB_TB_1MS) ? tick_1ms :
                  (BASE == STB_TB_10MS) ? tick_10ms : tick_100ms;
    stb_timer_cell #(
      .ET_W(ET_W)
    ) u_cell (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_mode(stb_mode_t'(I_MODE[g*2 +: 2])),
      .i_tick(tick),
      .i_enable(I_ENABLE[g]),
      .i_preset_time(I_PRESET_TIME[g*ET_W +: ET_W]),
      .o_q(q[g]),
      .o_elapsed_count(et[g*ET_W +: ET_W])
    );
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_Q <= '0;
      O_ELAPSED_COUNT <= '0;
    end else begin
      O_Q <= q;
      O_ELAPSED_COUNT <= et;
    end
  end

  // ==========================================================
  // Millisecond counter and interval requests
  logic [31:0] ms_count;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      ms_count <= `STB_MS_RST;
    end else if (tick_1ms) begin
      ms_count <= ms_count + 32'h1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_INTERVAL_VALID <= 1'b0;
      O_INTERVAL_VALUE <= 32'h0;
      O_MS_COUNT <= `STB_MS_RST;
    end else begin
      O_MS_COUNT <= ms_count;
      O_INTERVAL_VALID <= I_BEGIN_INTERVAL_SNAPSHOT ||
                          I_CALCULATE_INTERVAL_DIFFERENCE;
      if (I_BEGIN_INTERVAL_SNAPSHOT) begin
        O_INTERVAL_VALUE <= ms_count;
      end else if (I_CALCULATE_INTERVAL_DIFFERENCE) begin
        O_INTERVAL_VALUE <= ms_count - I_INTERVAL_START;
      end
    end
  end
endmodule

// >>> testbench/stb_timer_bank_assertions.sv
`timescale 1ns/100ps
// ====================
// Port checks of the timer bank
module stb_timer_bank_assertions
  import stb_pkg::*;
#(
  parameter int N_TMR = 4,
  parameter int ET_W = 16
) (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic [N_TMR*2-1:0] I_MODE,
  input wire logic [N_TMR-1:0] I_ENABLE,
  input wire logic [N_TMR*ET_W-1:0] I_PRESET_TIME,
  input wire logic [N_TMR-1:0] O_Q,
  input wire logic [N_TMR*ET_W-1:0] O_ELAPSED_COUNT,
  input wire logic I_BEGIN_INTERVAL_SNAPSHOT,
  input wire logic I_CALCULATE_INTERVAL_DIFFERENCE,
  input wire logic [31:0] I_INTERVAL_START,
  input wire logic O_INTERVAL_VALID,
  input wire logic [31:0] O_INTERVAL_VALUE,
  input wire logic [31:0] O_MS_COUNT
);
  wire logic bg = I_BEGIN_INTERVAL_SNAPSHOT;
  wire logic cl = I_CALCULATE_INTERVAL_DIFFERENCE;
  wire logic [ET_W-1:0] e1 = O_ELAPSED_COUNT[ET_W+:ET_W];
  wire logic [ET_W:0] e2 = {1'b0, O_ELAPSED_COUNT[2*ET_W+:ET_W]};
  wire logic [ET_W:0] p2 = {1'b0, I_PRESET_TIME[2*ET_W+:ET_W]};
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  a_answer_one: assert property (bg || cl |=> O_INTERVAL_VALID)
    else $error("answer missing");
  a_answer_none: assert property (!(bg || cl) |=> !O_INTERVAL_VALID)
    else $error("answer without request");
  a_begin_value: assert property (bg |=>
    O_INTERVAL_VALUE - $past(O_MS_COUNT) <= 32'h1)
    else $error("snapshot value off");
  a_calc_value: assert property (cl && !bg |=>
    O_INTERVAL_VALUE - ($past(O_MS_COUNT) - $past(I_INTERVAL_START))
    <= 32'h1) else $error("difference off");
  a_ms_step: assert property (O_MS_COUNT - $past(O_MS_COUNT) <= 32'h1)
    else $error("ms counter jumped");
  a_on_drop: assert property (I_MODE[1:0] == 2'h0 && !I_ENABLE[0]
    |-> ##2 !O_Q[0]) else $error("on-delay output stuck");
  a_off_hold: assert property (I_MODE[3:2] == 2'h1 && $past(I_ENABLE[1])
    && $past(I_ENABLE[1], 2) && $past(I_ENABLE[1], 3) |-> O_Q[1] && e1 == '0)
    else $error("off-delay not held");
  a_pulse_full: assert property (I_MODE[5:4] == 2'h2 && O_Q[2]
    && e2 + 1 < p2 |=> O_Q[2]) else $error("pulse cut short");
  c_on_done: cover property ($rose(O_Q[0]));
  c_off_done: cover property ($fell(O_Q[1]));
  c_pulse_done: cover property ($fell(O_Q[2]));
endmodule
bind stb_timer_bank stb_timer_bank_assertions #(.N_TMR(N_TMR), .ET_W(ET_W))
  u_chk (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_MODE(I_MODE),
  .I_ENABLE(I_ENABLE), .I_PRESET_TIME(I_PRESET_TIME), .O_Q(O_Q),
  .O_ELAPSED_COUNT(O_ELAPSED_COUNT), .O_MS_COUNT(O_MS_COUNT),
  .I_BEGIN_INTERVAL_SNAPSHOT(I_BEGIN_INTERVAL_SNAPSHOT),
  .I_CALCULATE_INTERVAL_DIFFERENCE(I_CALCULATE_INTERVAL_DIFFERENCE),
  .I_INTERVAL_START(I_INTERVAL_START), .O_INTERVAL_VALID(O_INTERVAL_VALID),
  .O_INTERVAL_VALUE(O_INTERVAL_VALUE));

// >>> testbench/stb_ctrl_model.sv
`timescale 1ns/100ps
// ====================
// Controlling program: fixed modes, registered enables
module stb_ctrl_model (
  input wire logic i_clk,
  input wire logic [3:0] i_en,
  input wire logic [63:0] i_pt,
  output logic [7:0] o_mode,
  output logic [3:0] o_enable = 4'h0,
  output logic [63:0] o_preset_time = 64'h0
);
  // One mode per slot, timers 32 96 33 37 only
  assign o_mode = 8'h24;
  always @(posedge i_clk) begin
    o_enable <= i_en;
    o_preset_time <= i_pt;
  end
endmodule

// >>> testbench/stb_timer_bank_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module stb_timer_bank_bench;
  import stb_pkg::*;
  logic clk = 0, nrst = 0, bgn = 0, calc = 0, vld;
  logic [31:0] start = 0, val, ms, cnt = 0, c, st;
  logic [3:0] en = 0, enq, q;
  logic [63:0] pt = 0, ptq, et;
  logic [7:0] md;
  int error_cnt = 0, n_tests = 0, s;
  // Slot, preset, wait, q and count enabled, q and count disabled
  logic [15:0] rows [5][7] = '{
    '{16'h0, 16'h3, 16'h28, 16'h1, 16'h3, 16'h0, 16'h0},
    '{16'h0, 16'h0, 16'h14, 16'h1, 16'h0, 16'h0, 16'h0},
    '{16'h1, 16'h4, 16'h28, 16'h1, 16'h0, 16'h0, 16'h4},
    '{16'h2, 16'h2, 16'h50, 16'h0, 16'h2, 16'h0, 16'h0},
    '{16'h3, 16'h4, 16'h1f4, 16'h0, 16'h3, 16'h0, 16'h0}};
  stb_ctrl_model u_stb_ctrl_model (.i_clk(clk), .i_en(en), .i_pt(pt),
    .o_mode(md), .o_enable(enq), .o_preset_time(ptq));
  stb_timer_bank #(.CYC_PER_MS(2)) u_stb_timer_bank (.I_CLK(clk),
    .I_NRST(nrst), .I_MODE(md), .I_ENABLE(enq), .I_PRESET_TIME(ptq),
    .O_Q(q), .O_ELAPSED_COUNT(et), .I_BEGIN_INTERVAL_SNAPSHOT(bgn),
    .I_CALCULATE_INTERVAL_DIFFERENCE(calc), .I_INTERVAL_START(start),
    .O_INTERVAL_VALID(vld), .O_INTERVAL_VALUE(val), .O_MS_COUNT(ms));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic wt(input logic [15:0] n);
    repeat (n) @(posedge clk);
  endtask
  task results;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    if (nrst) cnt <= cnt + 32'h1;
    if (cnt > 32'h1388) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    wt(16'h8);
    `CHK({q, et, ms, vld}, 101'h0)
    $display("reset done");
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      s = rows[i][0];
      pt[s*16 +: 16] <= rows[i][1];
      en[s] <= 1'b1;
      wt(rows[i][2]);
      `CHK(q[s], rows[i][3][0])
      `CHK(et[s*16 +: 16], rows[i][4])
      en[s] <= 1'b0;
      wt(rows[i][2]);
      `CHK(q[s], rows[i][5][0])
      `CHK(et[s*16 +: 16], rows[i][6])
      $display("row %0d done", i);
    end
    pt[47:32] <= 16'h3;
    en[2] <= 1'b1;
    wt(16'h2);
    en[2] <= 1'b0;
    wt(16'h1e);
    `CHK(q[2], 1'b1)
    wt(16'h28);
    `CHK(q[2], 1'b0)
    $display("pulse done");
    en[1] <= 1'b1;
    wt(16'ha);
    en[1] <= 1'b0;
    wt(16'h2);
    en[1] <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      wt(16'h1);
      `CHK(q[1], 1'b1)
    end
    $display("off-delay done");
    for (int k = 0; k < 3; k++) begin
      st = (k == 0) ? 32'h0 : (k == 1) ? 32'h10 : 32'hffff_fff0;
      bgn <= (k == 0);
      calc <= (k != 0);
      start <= st;
      wt(16'h1);
      c = cnt;
      bgn <= 1'b0;
      calc <= 1'b0;
      wt(16'h1);
      `CHK(vld, 1'b1)
      `CHK(val - ((c >> 1) - st) + 32'h2 <= 32'h4, 1'b1)
      wt(16'h64);
    end
    $display("interval done");
    results();
  end
endmodule
